//--- hw/peripheral_irq_enable_bank.sv
`timescale 1ns/1ns
`include "irq_enable_defines.svh"

module peripheral_irq_enable_bank #(
	parameter int NUM_REGS    = 6,
	parameter bit FULL_MEMORY = 1'b1
) (
	// Clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rst,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic                             pready,
	output logic [31:0]                      prdata,
	output logic                             pslverr,
	// Peripheral events, six groups of eight
	input  wire logic [8*NUM_REGS-1:0]       periph_event,
	// Requests to the processor core
	output irq_enable_pkg::irq_req_s         irq_req
);

	localparam int W = 8 * NUM_REGS;

	// Implemented enable bits depend on the memory variant
	localparam logic [47:0] EN_MASK =
		FULL_MEMORY ? `EN_MASK_FULL : `EN_MASK_SMALL;
	// Sources that exist, including those with fixed priority bits
	localparam logic [47:0] IMPL = EN_MASK | `PRIO_FIXED;

	// Refuse a bank size the register map cannot hold
	if (NUM_REGS != 6) begin : g_size_check
		$error("peripheral_irq_enable_bank needs six registers");
	end

	// Register state
	logic [W-1:0]              enable_q;
	logic [W-1:0]              priority_q;
	logic [W-1:0]              flags;
	irq_enable_pkg::irq_ctrl_s ctrl_q;

	// Bus response registers
	logic                      pready_q;
	logic [31:0]               prdata_q;
	logic                      pslverr_q;

	// Decoded access
	logic [4:0]                index;
	irq_enable_pkg::reg_kind_e kind;
	logic [2:0]                slot;
	logic                      access;
	logic                      commit;
	logic                      wr_commit;
	logic                      aligned;
	logic [W-1:0]              slot_mask;
	logic [W-1:0]              wr_spread;
	logic [W-1:0]              flag_clear;
	logic [7:0]                rd_byte;

	// Kind of register at a word index
	function automatic irq_enable_pkg::reg_kind_e
		decode_kind(input logic [4:0] idx);
		if (idx < `IDX_PRIO_FIRST) begin
			decode_kind = irq_enable_pkg::KIND_ENABLE;
		end else if (idx < `IDX_FLAG_FIRST) begin
			decode_kind = irq_enable_pkg::KIND_PRIORITY;
		end else if (idx < `IDX_CTRL) begin
			decode_kind = irq_enable_pkg::KIND_FLAG;
		end else if (idx == `IDX_CTRL) begin
			decode_kind = irq_enable_pkg::KIND_CONTROL;
		end else begin
			decode_kind = irq_enable_pkg::KIND_NONE;
		end
	endfunction

	// Position of a register within its group of six
	function automatic logic [2:0] decode_slot(input logic [4:0] idx);
		logic [4:0] rel;
		rel = idx;
		if (idx >= `IDX_FLAG_FIRST) begin
			rel = idx - `IDX_FLAG_FIRST;
		end else if (idx >= `IDX_PRIO_FIRST) begin
			rel = idx - `IDX_PRIO_FIRST;
		end
		decode_slot = rel[2:0];
	endfunction

	// One register byte taken out of a packed group
	function automatic logic [7:0] pick_byte(
		input logic [W-1:0] group,
		input logic [2:0]   sel
	);
		pick_byte = group[8*sel +: 8];
	endfunction

	// Address decode
	assign index     = paddr[6:2];
	assign aligned   = (paddr[1:0] == 2'h0) && (paddr[7] == 1'b0);
	assign kind      = aligned ? decode_kind(index)
		: irq_enable_pkg::KIND_NONE;
	assign slot      = decode_slot(index);
	assign access    = psel & penable;
	assign commit    = access & pready_q;
	assign wr_commit = commit & pwrite;

	// Byte lane of the addressed register, and the write data spread over it
	assign slot_mask = {{(W-8){1'b0}}, 8'hff} << (8 * slot);
	assign wr_spread = {NUM_REGS{pwdata[7:0]}} & slot_mask;

	// One wait state: answer in the second access cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= access & ~pready_q;
		end
	end

	// Error answer for unmapped or misaligned addresses
	always_ff @(posedge mclk) begin
		if (rst) begin
			pslverr_q <= 1'b0;
		end else if (access & ~pready_q) begin
			pslverr_q <= (kind == irq_enable_pkg::KIND_NONE);
		end else begin
			pslverr_q <= 1'b0;
		end
	end

	// Selected register byte for a read
	always_comb begin
		rd_byte = 8'h00;
		unique case (kind)
			irq_enable_pkg::KIND_ENABLE: begin
				rd_byte = pick_byte(enable_q, slot);
			end
			irq_enable_pkg::KIND_PRIORITY: begin
				rd_byte = pick_byte(priority_q, slot);
			end
			irq_enable_pkg::KIND_FLAG: begin
				rd_byte = pick_byte(flags, slot);
			end
			irq_enable_pkg::KIND_CONTROL: begin
				rd_byte[`CTRL_PRIO_BIT] = ctrl_q.priority_mode_enable;
				rd_byte[`CTRL_GATE_BIT] = ctrl_q.peripheral_group_gate;
			end
			irq_enable_pkg::KIND_NONE: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// Read data is captured with the ready answer; upper bits read zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			prdata_q <= 32'h0000_0000;
		end else if (access & ~pready_q & ~pwrite) begin
			prdata_q <= {24'h00_0000, rd_byte};
		end else begin
			prdata_q <= 32'h0000_0000;
		end
	end

	// Enable registers; absent and read-only bits stay zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			enable_q <= `EN_RST;
		end else if (wr_commit &&
			kind == irq_enable_pkg::KIND_ENABLE) begin
			enable_q <= (enable_q & ~slot_mask) |
				(wr_spread & EN_MASK);
		end
	end

	// Priority registers; serial 2 bits are fixed high
	always_ff @(posedge mclk) begin
		if (rst) begin
			priority_q <= `PRIO_RST & IMPL;
		end else if (wr_commit &&
			kind == irq_enable_pkg::KIND_PRIORITY) begin
			priority_q <= ((priority_q & ~slot_mask) |
				(wr_spread & EN_MASK)) | `PRIO_FIXED;
		end
	end

	// Mode register: priority mode and peripheral group gate
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_q <= '0;
		end else if (wr_commit &&
			kind == irq_enable_pkg::KIND_CONTROL) begin
			ctrl_q.priority_mode_enable  <= pwdata[`CTRL_PRIO_BIT];
			ctrl_q.peripheral_group_gate <= pwdata[`CTRL_GATE_BIT];
		end
	end

	// Software clears a flag by writing zero to it
	always_comb begin
		flag_clear = '0;
		if (wr_commit && kind == irq_enable_pkg::KIND_FLAG) begin
			flag_clear = slot_mask & ~wr_spread;
		end
	end

	// Request flags held per source
	irq_flag_bank #(
		.W     (W),
		.LEVEL (`FLAG_LEVEL),
		.IMPL  (IMPL)
	) u_flags (
		.mclk     (mclk),
		.rst      (rst),
		.event_in (periph_event),
		.clear_in (flag_clear),
		.flags_q  (flags)
	);

	// Gating of flags into the two request lines
	irq_request_combiner #(
		.W (W)
	) u_combine (
		.mclk          (mclk),
		.rst           (rst),
		.flags         (flags),
		.enables       (enable_q),
		.priority_bits (priority_q),
		.ctrl          (ctrl_q),
		.req_q         (irq_req)
	);

	// Bus outputs come straight from their registers
	assign pready  = pready_q;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

endmodule // peripheral_irq_enable_bank

//--- shared/irq_enable_defines.svh
`ifndef IRQ_ENABLE_DEFINES_SVH
`define IRQ_ENABLE_DEFINES_SVH
// Summary of operation
// - With priority mode off, a request needs the group gate and own enable.
// - Six separate enable registers, one bit per peripheral source.
// - Enable 1: bits 6..2 adc, rx1, tx1, sync1, t1 gate; 1 t2; 0 t1.
// - Enable 2: bit 7 osc fail, bit 6 reads 0, bits 5..0 as listed.
// - Enable 3: bit 7 t5 gate, bits 5:4 read-only 0, bits 3..0 listed.
// - Enable 4: capture/compare 10..3; bits 7:6 absent on small parts.
// - Enable 5: timers 7 gate..4 match; bits 7,6,5,3 absent on small parts.
// - Enable 6: bits 7:5 and 3 read 0; bit 4 nvm write; 2..0 comparators.
// - Enable bit 1 allows, 0 blocks; enables clear to 0 at reset.
// - Six priority registers; priority bits matter only in priority mode.
// - Flags set by hardware; software clears most; serial flags follow buffers.
// - Priority 1 selects high level, 0 low level; reset value is 1.

// Word indices of the registers; byte address is four times the index
`define IDX_EN_FIRST    5'h00
`define IDX_PRIO_FIRST  5'h06
`define IDX_FLAG_FIRST  5'h0c
`define IDX_CTRL        5'h12
`define IDX_LAST        5'h12

// Control register field positions
`define CTRL_PRIO_BIT   7
`define CTRL_GATE_BIT   6
`define CTRL_RST        8'h00

// Writable enable bits, register 6 in the top byte
`define EN_MASK_FULL    48'h17ff_ff8f_bf7f
`define EN_MASK_SMALL   48'h1717_3f8f_bf7f
`define EN_RST          48'h0000_0000_0000

// Priority bits that are read-only and stuck at one
`define PRIO_FIXED      48'h0000_0030_0000
`define PRIO_RST        48'hffff_ffff_ffff

// Flags that follow a serial buffer level instead of being sticky
`define FLAG_LEVEL      48'h0000_0030_0030
`define FLAG_RST        48'h0000_0000_0000
`endif

//--- shared/irq_enable_pkg.sv
package irq_enable_pkg;

	// Register groups seen by the bus decoder
	typedef enum logic [2:0] {
		KIND_ENABLE,
		KIND_PRIORITY,
		KIND_FLAG,
		KIND_CONTROL,
		KIND_NONE
	} reg_kind_e;

	// Mode bits that steer the request combiner
	typedef struct packed {
		logic priority_mode_enable;
		logic peripheral_group_gate;
	} irq_ctrl_s;

	// Requests toward the processor core
	typedef struct packed {
		logic high;
		logic low;
	} irq_req_s;

endpackage

//--- hw/irq_flag_bank.sv
`timescale 1ns/1ns
`include "irq_enable_defines.svh"

module irq_flag_bank #(
	parameter int          W     = 48,
	parameter logic [47:0] LEVEL = `FLAG_LEVEL,
	parameter logic [47:0] IMPL  = `EN_MASK_FULL
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// Event side
	input  wire logic [W-1:0] event_in,
	input  wire logic [W-1:0] clear_in,
	// Flag state
	output logic      [W-1:0] flags_q
);

	// Sticky flags: an event in the clear cycle wins; level flags track input
	always_ff @(posedge mclk) begin
		if (rst) begin
			flags_q <= `FLAG_RST;
		end else begin
			flags_q <= IMPL & ((LEVEL & event_in) |
				(~LEVEL & ((flags_q & ~clear_in) | event_in)));
		end
	end

endmodule // irq_flag_bank

//--- hw/irq_request_combiner.sv
`timescale 1ns/1ns

module irq_request_combiner #(
	parameter int W = 48
) (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst,
	// Sources and their settings
	input  wire logic [W-1:0]             flags,
	input  wire logic [W-1:0]             enables,
	input  wire logic [W-1:0]             priority_bits,
	input  wire irq_enable_pkg::irq_ctrl_s ctrl,
	// Requests to the core
	output irq_enable_pkg::irq_req_s      req_q
);

	logic [W-1:0] active;
	logic         any_high;
	logic         any_low;

	// A source asks only with flag and enable both set
	assign active   = flags & enables;
	assign any_high = |(active & priority_bits);
	assign any_low  = |(active & ~priority_bits);

	// Level routing; in compatible mode everything uses the high line
	always_ff @(posedge mclk) begin
		if (rst) begin
			req_q <= '0;
		end else if (ctrl.priority_mode_enable) begin
			req_q.high <= any_high;
			req_q.low  <= any_low & ctrl.peripheral_group_gate;
		end else begin
			req_q.high <= (|active) & ctrl.peripheral_group_gate;
			req_q.low  <= 1'b0;
		end
	end

endmodule // irq_request_combiner

//--- tb/irq_bank_assertions.sv
`timescale 1ns/1ns

module irq_bank_checker #(
	parameter int NUM_REGS = 6
) (
	// Clock and reset
	input wire logic                     mclk,
	input wire logic                     rst,
	// Register bus
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [7:0]               paddr,
	input wire logic [31:0]              pwdata,
	input wire logic                     pready,
	input wire logic [31:0]              prdata,
	input wire logic                     pslverr,
	// Sources and requests
	input wire logic [8*NUM_REGS-1:0]    periph_event,
	input wire irq_enable_pkg::irq_req_s irq_req
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Bus answers: one wait state, one cycle long
	a_ready_access: assert property (
		pready |-> psel && penable && $past(penable))
		else $error("Ready outside an access phase");
	a_ready_single: assert property (
		pready |=> !pready) else $error("Ready held too long");
	a_ready_timing: assert property (
		psel && !penable |-> ##2 pready) else $error("Ready late");
	a_err_unmapped: assert property (
		pready && (paddr > 8'h48 || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("No error for unmapped address");
	a_ok_mapped: assert property (
		pready && paddr <= 8'h48 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("Error on mapped address");
	a_upper_zero: assert property (
		pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("Upper read bits not zero");
	// Reset quiets everything, checked during reset itself
	a_reset_quiet: assert property (disable iff (1'b0)
		rst |=> !pready && !pslverr && irq_req == 2'b00)
		else $error("Outputs active after reset");
	// A request rises only after an event or a register write
	a_irq_cause: assert property (
		$rose(irq_req.high) || $rose(irq_req.low) |->
		$past(|periph_event, 2) || $past(pready && pwrite, 2))
		else $error("Request rose without cause");

	// Main scenarios
	c_err: cover property (pready && pslverr);
	c_high: cover property ($rose(irq_req.high));
	c_low: cover property ($rose(irq_req.low));
endmodule // irq_bank_checker

bind peripheral_irq_enable_bank irq_bank_checker #(.NUM_REGS(NUM_REGS)) u_chk (
	.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .periph_event(periph_event),
	.irq_req(irq_req));

//--- tb/tb.sv
`timescale 1ns/1ns

module tb;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [47:0] ev = 48'h0;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [33:0] q[$];
	logic [33:0] nt;
	logic [31:0] x = 32'd43;
	logic [7:0]  v;
	logic [7:0]  em[6] = '{8'h7f, 8'hbf, 8'h8f, 8'hff, 8'hff, 8'h17};
	int          err_total = 0;
	int          n_tests = 0;
	int          n;
	irq_enable_pkg::irq_req_s irq_req;

	// Clock
	always #4 mclk = ~mclk;

	peripheral_irq_enable_bank uut (.mclk(mclk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.periph_event(ev), .irq_req(irq_req));

	function logic [31:0] rnd();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction

	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task summarize();
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One transfer; the note tells the monitor what to expect
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic c);
		int i;
		q.push_back({c, a > 8'h48 || a[1:0] != 2'h0, d});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= w ? d : rnd();
		@(posedge mclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1) begin
			err_total++;
			summarize();
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, e, 1'b1);
	endtask

	task rel();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task pulse(input int k);
		ev[k] <= 1'b1;
		@(posedge mclk);
		ev <= 48'h0;
	endtask

	task irq_is(input logic [1:0] e);
		repeat (3) @(posedge mclk);
		chk({30'h0, irq_req}, {30'h0, e});
	endtask

	// Monitor takes the oldest note at each answer
	always @(posedge mclk) begin
		if (pready === 1'b1) begin
			nt = q.pop_front();
			chk({31'h0, pslverr}, {31'h0, nt[32]});
			if (nt[33]) chk(prdata, nt[31:0]);
		end
	end

	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		// Reset values
		for (n = 0; n < 6; n++) begin
			rd(8'(4*n), 32'h0);
			rd(8'(8'h18+4*n), {24'h0, em[n] | (n == 2 ? 8'h30 : 8'h00)});
			rd(8'(8'h30+4*n), 32'h0);
		end
		rd(8'h48, 32'h0);
		// Random writes keep only implemented bits
		for (n = 0; n < 12; n++) begin
			v = 8'(rnd());
			wr(8'(4*n), {24'h0, v});
			rd(8'(4*n), {24'h0, v & em[n%6] | (n == 8 ? 8'h30 : 8'h00)});
		end
		// Unmapped and misaligned places
		wr(8'h4c, 32'hff);
		rd(8'h80, 32'h0);
		rd(8'h05, 32'h0);
		rel();
		// Requests through each enable register, gate off then on
		for (n = 0; n < 6; n++) begin
			wr(8'(4*n), 32'hff);
			wr(8'h48, 32'h00);
			rel();
			pulse(8*n);
			irq_is(2'b00);
			wr(8'h48, 32'h40);
			rel();
			irq_is(2'b10);
			wr(8'(4*n), 32'h00);
			rel();
			irq_is(2'b00);
			rd(8'(8'h30+4*n), 32'h1);
			wr(8'(8'h30+4*n), 32'h00);
			rd(8'(8'h30+4*n), 32'h0);
			rel();
		end
		// Serial flags follow their level; a held event beats a clear
		ev <= 48'h0000_0000_0031;
		wr(8'h30, 32'h00);
		rd(8'h30, 32'h31);
		ev <= 48'h0;
		wr(8'h30, 32'h00);
		rd(8'h30, 32'h0);
		// Priority mode steers to high or low level
		wr(8'h00, 32'h01);
		wr(8'h18, 32'hff);
		wr(8'h48, 32'h80);
		rel();
		pulse(0);
		irq_is(2'b10);
		wr(8'h18, 32'h00);
		rel();
		irq_is(2'b00);
		wr(8'h48, 32'hc0);
		rel();
		irq_is(2'b01);
		// A second reset clears the enables
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		rd(8'h00, 32'h0);
		rd(8'h18, 32'h7f);
		rd(8'h30, 32'h0);
		rd(8'h48, 32'h0);
		rel();
		irq_is(2'b00);
		summarize();
	end
endmodule // tb
